// >>> logic/flow_speed_monitor.v
// Purpose: flow confirmation and start-up minimum speed supervisor
// Assumes: start_req, flow_confirm_in and motor_speed_rpm are synchronous
// Notes: APB slave with zero wait states; window values in 0.1 s units
`timescale 1ns/10ps
`default_nettype none
`include "flow_mon_defs.vh"

module flow_speed_monitor #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter TW = 16
) (
    input wire ref_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire start_req,
    input wire flow_confirm_in,
    input wire [15:0] motor_speed_rpm,
    output reg motor_run,
    output reg running,
    output reg verifying_flow,
    output reg flow_alarm,
    output reg speed_alarm,
    output wire irq
);

    localparam FL_IDLE = 2'd0;
    localparam FL_VALIDATE = 2'd1;
    localparam FL_VERIFY = 2'd2;
    localparam FL_CONFIRMED = 2'd3;

    // registers
    reg [2:0] ctrl_q;
    reg [TW-1:0] valid_time_q;
    reg [TW-1:0] verify_time_q;
    reg [TW-1:0] start_delay_q;
    reg [TW-1:0] max_start_time_q;
    reg [15:0] trip_speed_threshold_q;
    reg [15:0] low_speed_limit_rpm_q;
    reg [`IRQ_W-1:0] irq_stat_q;
    reg [`IRQ_W-1:0] irq_mask_q;

    // internal state
    reg [31:0] div_q;
    reg tick_q;
    reg start_d1_q;
    reg tripped_q;
    reg [1:0] fl_state_q;
    reg [1:0] fl_state_d;
    reg reached_q;

    wire wr_en;
    wire rd_setup;
    wire mapped;
    wire trip_reset;
    wire fc_assigned;
    wire msm_enable;
    wire start_edge;
    wire clr_timers;
    wire active;
    wire fl_done;
    wire sd_done;
    wire ms_done;
    wire fl_clr;
    wire [TW-1:0] fl_limit;
    wire speed_ok;
    wire flow_trip;
    wire start_trip;
    wire low_trip;
    wire any_trip;
    wire flow_ok_evt;
    wire run_d;
    wire [`IRQ_W-1:0] irq_set;
    wire [`IRQ_W-1:0] irq_clr;
    reg flow_trip_c;

    // apb decode
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_VALID_TIME) ||
                    (paddr == `OFS_VERIFY_TIME) ||
                    (paddr == `OFS_START_DELAY) ||
                    (paddr == `OFS_MAX_START) ||
                    (paddr == `OFS_TRIP_SPEED) ||
                    (paddr == `OFS_LOW_LIMIT) || (paddr == `OFS_STATUS) ||
                    (paddr == `OFS_IRQ_STAT) || (paddr == `OFS_IRQ_MASK);
    assign pslverr = psel && penable && !mapped;

    // trip reset is a write-one pulse, it never stores
    assign trip_reset = wr_en && (paddr == `OFS_CTRL) &&
                        pwdata[`CTRL_TRIP_RESET];
    assign fc_assigned = ctrl_q[`CTRL_FC_ASSIGNED];
    assign msm_enable = ctrl_q[`CTRL_MSM_ENABLE];

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `RST_CTRL;
            valid_time_q <= `RST_VALID_TIME;
            verify_time_q <= `RST_VERIFY_TIME;
            start_delay_q <= `RST_START_DELAY;
            max_start_time_q <= `RST_MAX_START;
            trip_speed_threshold_q <= `RST_TRIP_SPEED;
            low_speed_limit_rpm_q <= `RST_LOW_LIMIT;
            irq_mask_q <= {`IRQ_W{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `OFS_CTRL: begin
                    ctrl_q <= {1'b0, pwdata[1:0]};
                end
                `OFS_VALID_TIME: begin
                    valid_time_q <= pwdata[TW-1:0];
                end
                `OFS_VERIFY_TIME: begin
                    verify_time_q <= pwdata[TW-1:0];
                end
                `OFS_START_DELAY: begin
                    start_delay_q <= pwdata[TW-1:0];
                end
                `OFS_MAX_START: begin
                    max_start_time_q <= pwdata[TW-1:0];
                end
                `OFS_TRIP_SPEED: begin
                    trip_speed_threshold_q <= pwdata[15:0];
                end
                `OFS_LOW_LIMIT: begin
                    low_speed_limit_rpm_q <= pwdata[15:0];
                end
                `OFS_IRQ_MASK: begin
                    irq_mask_q <= pwdata[`IRQ_W-1:0];
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // read data is captured in the setup cycle so it is a flop output
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            case (paddr)
                `OFS_CTRL: prdata <= {29'h0, ctrl_q};
                `OFS_VALID_TIME: prdata <= {16'h0, valid_time_q};
                `OFS_VERIFY_TIME: prdata <= {16'h0, verify_time_q};
                `OFS_START_DELAY: prdata <= {16'h0, start_delay_q};
                `OFS_MAX_START: prdata <= {16'h0, max_start_time_q};
                `OFS_TRIP_SPEED: prdata <= {16'h0, trip_speed_threshold_q};
                `OFS_LOW_LIMIT: prdata <= {16'h0, low_speed_limit_rpm_q};
                `OFS_STATUS: prdata <= {24'h0, reached_q,
                    (fl_state_q == FL_CONFIRMED), speed_alarm, flow_alarm,
                    tripped_q, running, motor_run, verifying_flow};
                `OFS_IRQ_STAT: prdata <= {28'h0, irq_stat_q};
                `OFS_IRQ_MASK: prdata <= {28'h0, irq_mask_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // timebase tick: long count kept a parameter so benches can shorten it
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (div_q >= TICK_CYCLES - 1) begin
            div_q <= 32'h00000000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_d1_q <= 1'b0;
        end else begin
            start_d1_q <= start_req;
        end
    end

    assign start_edge = start_req && !start_d1_q;
    assign clr_timers = start_edge || !start_req;
    assign active = start_req && !tripped_q;

    // flow window timer is reused: cleared when validation hands over
    assign fl_clr = clr_timers ||
                    (fl_state_q == FL_VALIDATE && flow_confirm_in);
    assign fl_limit = (fl_state_q == FL_VERIFY) ? verify_time_q :
                      valid_time_q;

    tick_timer #(.W(TW)) u_flow_timer (
        .clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick_q),
        .clr(fl_clr),
        .en(active && (fl_state_q == FL_VALIDATE ||
                       fl_state_q == FL_VERIFY)),
        .limit(fl_limit),
        .done(fl_done)
    );

    // both start timers share one clear and one enable
    tick_timer #(.W(TW)) u_delay_timer (
        .clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick_q),
        .clr(clr_timers),
        .en(active),
        .limit(start_delay_q),
        .done(sd_done)
    );

    tick_timer #(.W(TW)) u_max_start_timer (
        .clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick_q),
        .clr(clr_timers),
        .en(active),
        .limit(max_start_time_q),
        .done(ms_done)
    );

    // flow confirmation sequencer
    always @* begin
        fl_state_d = fl_state_q;
        flow_trip_c = 1'b0;
        case (fl_state_q)
            FL_IDLE: begin
                if (start_edge && !tripped_q) begin
                    // bypassed without an assigned input; active input skips
                    fl_state_d = !fc_assigned ? FL_CONFIRMED :
                                 flow_confirm_in ? FL_VERIFY :
                                 FL_VALIDATE;
                end
            end
            FL_VALIDATE: begin
                if (!start_req) begin
                    fl_state_d = FL_IDLE;
                end else if (flow_confirm_in) begin
                    fl_state_d = FL_VERIFY;
                end else if (fl_done) begin
                    fl_state_d = FL_IDLE;
                    flow_trip_c = 1'b1;
                end
            end
            FL_VERIFY: begin
                if (!start_req) begin
                    fl_state_d = FL_IDLE;
                end else if (!flow_confirm_in) begin
                    fl_state_d = FL_IDLE;
                    flow_trip_c = 1'b1;
                end else if (fl_done) begin
                    fl_state_d = FL_CONFIRMED;
                end
            end
            FL_CONFIRMED: begin
                if (!start_req) begin
                    fl_state_d = FL_IDLE;
                end
            end
            default: begin
                fl_state_d = FL_IDLE;
            end
        endcase
        if (flow_trip_c || start_trip || low_trip || tripped_q) begin
            fl_state_d = FL_IDLE;
        end
    end

    assign flow_trip = flow_trip_c && fc_assigned && !tripped_q;
    assign flow_ok_evt = (fl_state_q == FL_VERIFY) &&
                         (fl_state_d == FL_CONFIRMED);

    // own threshold only; the low speed limit register is never compared
    assign speed_ok = (motor_speed_rpm >=
                       trip_speed_threshold_q);
    // a delay not below the max start time trips before motor_run rises
    assign start_trip = msm_enable && active && ms_done &&
                        !reached_q;
    assign low_trip = msm_enable && active && reached_q &&
                      !speed_ok;
    assign any_trip = flow_trip || start_trip || low_trip;
    assign run_d = active && sd_done && !any_trip;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fl_state_q <= FL_IDLE;
            reached_q <= 1'b0;
        end else begin
            fl_state_q <= fl_state_d;
            if (clr_timers || tripped_q) begin
                reached_q <= 1'b0;
            end else if (active && sd_done && speed_ok) begin
                reached_q <= 1'b1;
            end
        end
    end

    // latched trip and alarms; a new trip wins over the reset pulse
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tripped_q <= 1'b0;
            flow_alarm <= 1'b0;
            speed_alarm <= 1'b0;
        end else begin
            tripped_q <= any_trip || (tripped_q && !trip_reset);
            flow_alarm <= flow_trip ||
                          (flow_alarm && !trip_reset);
            speed_alarm <= start_trip || low_trip ||
                           (speed_alarm && !trip_reset);
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_run <= 1'b0;
            running <= 1'b0;
            verifying_flow <= 1'b0;
        end else begin
            motor_run <= run_d;
            // normal running needs both flow confirmed and speed reached
            running <= run_d && reached_q &&
                       (fl_state_d == FL_CONFIRMED);
            verifying_flow <= (fl_state_d == FL_VALIDATE) ||
                              (fl_state_d == FL_VERIFY);
        end
    end

    // sticky interrupt status, write one to clear, set beats clear
    assign irq_set = {flow_ok_evt, low_trip, start_trip, flow_trip};
    assign irq_clr = (wr_en && paddr == `OFS_IRQ_STAT) ?
                     pwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= {`IRQ_W{1'b0}};
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

endmodule // flow_speed_monitor

`default_nettype wire

// >>> include/flow_mon_defs.vh
// Purpose: constants for the flow confirmation and minimum speed monitor
// Assumes: 40 MHz ref_clk, window settings in tenths of a second
// Notes: register offsets are byte addresses on the APB slave
`ifndef FLOW_MON_DEFS_VH
`define FLOW_MON_DEFS_VH

`define CLK_HZ 40000000
`define TICK_TIME_MS 100
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_TIME_MS)

`define OFS_CTRL 8'h00
`define OFS_VALID_TIME 8'h04
`define OFS_VERIFY_TIME 8'h08
`define OFS_START_DELAY 8'h0C
`define OFS_MAX_START 8'h10
`define OFS_TRIP_SPEED 8'h14
`define OFS_LOW_LIMIT 8'h18
`define OFS_STATUS 8'h1C
`define OFS_IRQ_STAT 8'h20
`define OFS_IRQ_MASK 8'h24

`define CTRL_FC_ASSIGNED 0
`define CTRL_MSM_ENABLE 1
`define CTRL_TRIP_RESET 2

`define ST_VERIFYING 0
`define ST_MOTOR_RUN 1
`define ST_RUNNING 2
`define ST_TRIPPED 3
`define ST_FLOW_ALARM 4
`define ST_SPEED_ALARM 5
`define ST_FLOW_OK 6
`define ST_SPEED_OK 7

`define IRQ_FLOW_TRIP 0
`define IRQ_START_TRIP 1
`define IRQ_LOW_TRIP 2
`define IRQ_FLOW_OK 3
`define IRQ_W 4

`define RST_CTRL 3'h0
`define RST_VALID_TIME 16'h0064
`define RST_VERIFY_TIME 16'h0096
`define RST_START_DELAY 16'h0000
`define RST_MAX_START 16'h0064
`define RST_TRIP_SPEED 16'h0000
`define RST_LOW_LIMIT 16'h0000

`endif

// >>> logic/tick_timer.v
// Purpose: saturating counter of timebase ticks with a compare limit
// Assumes: tick is a one-cycle enable pulse
// Notes: clear has priority over counting
`timescale 1ns/10ps
`default_nettype none

module tick_timer #(
    parameter W = 16
) (
    input wire clk,
    input wire rst_n,
    input wire tick,
    input wire clr,
    input wire en,
    input wire [W-1:0] limit,
    output wire done
);

    reg [W-1:0] count_q;
    wire at_max;

    assign at_max = &count_q;
    assign done = (count_q >= limit);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {W{1'b0}};
        end else if (clr) begin
            count_q <= {W{1'b0}};
        end else if (en && tick && !at_max) begin
            count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule // tick_timer

`default_nettype wire

// >>> tb/flow_partner.sv
// Purpose: far side model, flow contact and motor speed feedback
// Assumes: bench steers valve_open and the speed ceiling
// Notes: speed ramps while motor_run is high and decays when it drops
`timescale 1ns/10ps
`default_nettype none
module flow_partner (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic motor_run,
    input wire logic valve_open,
    input wire logic [15:0] speed_cap,
    output logic flow_confirm_in,
    output logic [15:0] motor_speed_rpm
);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flow_confirm_in <= 1'b0;
            motor_speed_rpm <= 16'h0000;
        end else begin
            flow_confirm_in <= valve_open;
            // a lowered ceiling drops speed at once, like a current limit
            if (!motor_run)
                motor_speed_rpm <= motor_speed_rpm >> 1;
            else if (motor_speed_rpm + 16'h0010 > speed_cap)
                motor_speed_rpm <= speed_cap;
            else
                motor_speed_rpm <= motor_speed_rpm + 16'h0010;
        end
    end
endmodule // flow_partner
`default_nettype wire

// >>> tb/flow_speed_monitor_checker.sv
// Purpose: port level checks on the flow and speed supervisor
// Assumes: single clock, async active-low reset
// Notes: trip reset is bit 2 written to the control word
`timescale 1ns/10ps
`default_nettype none
module flow_speed_monitor_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic start_req,
    input wire logic flow_confirm_in,
    input wire logic motor_run,
    input wire logic running,
    input wire logic verifying_flow,
    input wire logic flow_alarm,
    input wire logic speed_alarm
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic clr_w;
    assign clr_w = psel && penable && pwrite && paddr == 8'h00 && pwdata[2];
    sequence s_drop;
        verifying_flow && start_req && $past(start_req)
            && $past(flow_confirm_in) && !flow_confirm_in;
    endsequence
    sequence s_trip;
        ##1 flow_alarm && !motor_run;
    endsequence
    property p_flow_drop;
        s_drop |-> s_trip;
    endproperty
    property p_flow_hold;
        flow_alarm && !clr_w |=> flow_alarm;
    endproperty
    property p_speed_hold;
        speed_alarm && !clr_w |=> speed_alarm;
    endproperty
    property p_trip_off;
        flow_alarm || speed_alarm |-> !motor_run && !running;
    endproperty
    property p_stop_clear;
        $fell(start_req) |=> !verifying_flow && !motor_run && !running;
    endproperty
    property p_verify_start;
        verifying_flow |-> $past(start_req);
    endproperty
    property p_run_excl;
        running |-> motor_run && !verifying_flow;
    endproperty
    property p_err;
        psel && penable && paddr > 8'h24 |-> pslverr;
    endproperty
    a_flow_drop: assert property (p_flow_drop)
        else $error("flow drop did not trip");
    a_flow_hold: assert property (p_flow_hold)
        else $error("flow alarm not held");
    a_speed_hold: assert property (p_speed_hold)
        else $error("speed alarm not held");
    a_trip_off: assert property (p_trip_off)
        else $error("motor on while tripped");
    a_stop_clear: assert property (p_stop_clear)
        else $error("stop did not clear");
    a_verify_start: assert property (p_verify_start)
        else $error("verifying without start");
    a_run_excl: assert property (p_run_excl)
        else $error("running while unconfirmed");
    a_err: assert property (p_err)
        else $error("unmapped access without error");
endmodule // flow_speed_monitor_checker
bind flow_speed_monitor flow_speed_monitor_checker chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .start_req(start_req), .flow_confirm_in(flow_confirm_in),
    .motor_run(motor_run), .running(running),
    .verifying_flow(verifying_flow), .flow_alarm(flow_alarm),
    .speed_alarm(speed_alarm));
`default_nettype wire

// >>> tb/tb.sv
// Purpose: directed bench for the flow and speed supervisor
// Assumes: tick shortened to 10 clocks, so windows are tens of cycles
// Notes: pin vector is flow, speed, motor_run, running, verifying, irq
`timescale 1ns/10ps
`default_nettype none
`include "flow_mon_defs.vh"
module tb;
    logic ref_clk, rst_n, psel, penable, pwrite, start_req, valve_open, hit;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, flow_confirm_in, motor_run, running, irq;
    logic verifying_flow, flow_alarm, speed_alarm;
    logic [15:0] motor_speed_rpm, speed_cap;
    int num_errors = 0;
    int n_compared = 0;
    int i;
    flow_speed_monitor #(.TICK_CYCLES(10), .TW(16)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_req(start_req),
        .flow_confirm_in(flow_confirm_in), .motor_speed_rpm(motor_speed_rpm),
        .motor_run(motor_run), .running(running),
        .verifying_flow(verifying_flow), .flow_alarm(flow_alarm),
        .speed_alarm(speed_alarm), .irq(irq));
    flow_partner far_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .motor_run(motor_run),
        .valve_open(valve_open), .speed_cap(speed_cap),
        .flow_confirm_in(flow_confirm_in), .motor_speed_rpm(motor_speed_rpm));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #500000;
        num_errors++;
        results();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] pins();
        return {26'h0, flow_alarm, speed_alarm, motor_run, running,
                verifying_flow, irq};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // holds the whole request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        q = prdata;
        hit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask
    task automatic restart(input logic [31:0] ctrl);
        start_req <= 1'b0;
        valve_open <= 1'b0;
        apb(1'b1, `OFS_CTRL, 32'h0000_0004);
        apb(1'b1, `OFS_IRQ_STAT, 32'h0000_000F);
        apb(1'b1, `OFS_CTRL, ctrl);
        tick(2);
        chk(pins(), 32'h0000_0000);
    endtask
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, start_req, valve_open} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        speed_cap = 16'h0400;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`OFS_CTRL, 32'h0000_0000);
        rd(`OFS_VALID_TIME, 32'h0000_0064);
        rd(`OFS_VERIFY_TIME, 32'h0000_0096);
        rd(`OFS_MAX_START, 32'h0000_0064);
        rd(8'h30, 32'h0000_0000);
        chk({31'h0, hit}, 32'h0000_0001);
        $display("test defaults done");
        apb(1'b1, `OFS_VALID_TIME, 32'h0000_0005);
        apb(1'b1, `OFS_VERIFY_TIME, 32'h0000_0004);
        apb(1'b1, `OFS_MAX_START, 32'h0000_0032);
        apb(1'b1, `OFS_TRIP_SPEED, 32'h0000_0100);
        apb(1'b1, `OFS_LOW_LIMIT, 32'h0000_0040);
        apb(1'b1, `OFS_IRQ_MASK, 32'h0000_000F);
        restart(32'h0000_0003);
        valve_open <= 1'b1;
        start_req <= 1'b1;
        tick(3);
        chk(pins(), 32'h0000_000A);
        for (i = 0; i < 200 && running !== 1'b1; i++) tick(1);
        chk(pins(), 32'h0000_000D);
        rd(`OFS_STATUS, 32'h0000_00C6);
        rd(`OFS_IRQ_STAT, 32'h0000_0008);
        apb(1'b1, `OFS_IRQ_STAT, 32'h0000_0008);
        rd(`OFS_IRQ_STAT, 32'h0000_0000);
        // ceiling sits above the low limit but below the trip threshold
        speed_cap <= 16'h0080;
        for (i = 0; i < 30 && speed_alarm !== 1'b1; i++) tick(1);
        chk(pins(), 32'h0000_0011);
        rd(`OFS_IRQ_STAT, 32'h0000_0004);
        speed_cap <= 16'h0400;
        tick(40);
        chk(pins(), 32'h0000_0011);
        $display("test run and low speed done");
        apb(1'b1, `OFS_VERIFY_TIME, 32'h0000_0008);
        restart(32'h0000_0001);
        valve_open <= 1'b1;
        start_req <= 1'b1;
        tick(20);
        chk(pins(), 32'h0000_000A);
        valve_open <= 1'b0;
        for (i = 0; i < 20 && flow_alarm !== 1'b1; i++) tick(1);
        chk(pins(), 32'h0000_0021);
        rd(`OFS_IRQ_STAT, 32'h0000_0001);
        $display("test flow drop done");
        restart(32'h0000_0001);
        apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0000);
        start_req <= 1'b1;
        tick(30);
        chk(pins(), 32'h0000_000A);
        for (i = 0; i < 60 && flow_alarm !== 1'b1; i++) tick(1);
        chk(pins(), 32'h0000_0020);
        apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
        tick(1);
        chk(pins(), 32'h0000_0021);
        apb(1'b1, `OFS_IRQ_STAT, 32'h0000_0001);
        tick(1);
        chk(pins(), 32'h0000_0020);
        $display("test validation expiry done");
        restart(32'h0000_0000);
        start_req <= 1'b1;
        tick(30);
        chk(pins(), 32'h0000_000C);
        start_req <= 1'b0;
        tick(2);
        chk(pins(), 32'h0000_0000);
        $display("test bypass and stop done");
        apb(1'b1, `OFS_START_DELAY, 32'h0000_0006);
        apb(1'b1, `OFS_MAX_START, 32'h0000_0005);
        apb(1'b1, `OFS_IRQ_MASK, 32'h0000_000F);
        restart(32'h0000_0002);
        start_req <= 1'b1;
        hit = 1'b0;
        for (i = 0; i < 150; i++) begin
            tick(1);
            if (motor_run !== 1'b0 || verifying_flow !== 1'b0)
                hit = 1'b1;
        end
        chk({31'h0, hit}, 32'h0000_0000);
        chk(pins(), 32'h0000_0011);
        rd(`OFS_IRQ_STAT, 32'h0000_0002);
        $display("test start time trip done");
        results();
    end
endmodule // tb
`default_nettype wire
